/* File: logic/drc_core.sv */
// Drive reset sources, restart gating, keypad control and command decoder
//
// Overview of operation
// - Selector 4 enables keypad keys; reverse gated
// - Up/Down show and step keypad reference, accelerating
// - Stop key resets; running with stop function enabled needs Run held
// - Reset-request parameter rising edge resets drive
// - Host writing 100 to user-trip resets
// - Auto-reset setting gives fourth reset source
// - Latched hardware fault ignores every reset
// - Memory fault: reset only with default codes
// - Non-latching sequencer restarts on enable and run
// - Latching sequencer also needs not-stop active
// - Stop-key reset waits for run input edge
// - Motor-set selector picks set, lights decimal
// - Card write flashes right decimal two seconds
// - Power-up waits five seconds for option copy
// - 1000 saves only on mains; 1001 always
// - 1070 resets options; 1233/1244 load defaults
// - 1253-1256 change drive mode, optionally keep menus
// - 2001 writes boot block 1, clears copy mode
// - Thousands codes pick card operation per digit
// - 9555-9999 card flags and whole-card erase
// - 110zy codes move nameplate data
// - 12000/12001 immediate; others wait for reset
// - Success clears command; failure trips, keeps value
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`include "drc_defines.svh"
module drc_core
	import drc_pkg::*;
#(
	parameter int FLASH_CYC = `DRC_FLASH_CYC,
	parameter int OPT_WAIT_CYC = `DRC_OPT_WAIT_CYC,
	parameter int STEP_CYC = `DRC_STEP_CYC,
	parameter int AUTO_CYC = `DRC_AUTO_CYC,
	parameter logic [15:0] KEYREF_MAX = 16'hffff
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire drc_keys_type keys,
	input wire drc_seq_type seq,
	input wire logic status_mode,
	input wire logic running,
	input wire logic trip_active,
	input wire logic hw_fault_trip,
	input wire logic memory_fault_trip,
	input wire logic undervoltage_flag,
	input wire logic aux_supply_flag,
	input wire logic opt_copy_req,
	input wire logic opt_copy_done,
	input wire drc_ack_type act_ack,
	output drc_act_type act,
	output logic drive_reset,
	output logic restart,
	output logic action_trip,
	output logic key_run_cmd,
	output logic key_stop_cmd,
	output logic key_rev_cmd,
	output logic [15:0] keypad_reference,
	output logic show_keyref,
	output logic alt_motor_set,
	output logic dp_alt_set,
	output logic dp_right,
	output logic [1:0] display_filter,
	output logic powerup_busy
);

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [2:0] reference_selector;
		logic reverse_key_enable;
		logic stop_fn_en;
		logic latch_seq;
		logic motor_set_selector;
		logic [3:0] auto_reset_setting;
		logic [2:0] card_copy_mode;
		logic [15:0] command_param;
		logic reset_request_param;
		logic rst_req_q;
		logic [7:0] user_trip_param;
		logic host_hit;
		logic [15:0] keyref;
		logic show_keyref;
		logic [7:0] hold_cnt;
		logic [31:0] step_tmr;
		drc_keys_type keys_q;
		logic [2:0] run_q;
		drc_act_type act;
		logic busy;
		drc_res_type result;
		logic drive_reset;
		logic restart;
		logic action_trip;
		logic wait_edge;
		logic key_run_cmd;
		logic key_stop_cmd;
		logic key_rev_cmd;
		logic [31:0] flash_cnt;
		logic [31:0] pwr_cnt;
		logic pwr_busy;
		logic pwr_started;
		logic [1:0] display_filter;
		logic [31:0] auto_tmr;
		logic [3:0] auto_cnt;
	} drc_state_type;

	drc_state_type st;
	drc_state_type next_st;

	////////////////////////////////////////////////////////////////////////
	// Command decode

	function automatic drc_act_type decode(input logic [15:0] c);
		drc_act_type a;
		logic [15:0] r;
		a.req = 1'b1;
		a.arg = 10'h000;
		r = c;
		case (c)
			`DRC_C_SAVE: a.op = OP_SAVE;
			`DRC_C_SAVE_ANY: a.op = OP_SAVE_ANY;
			`DRC_C_OPT_RST: a.op = OP_OPT_RESET;
			`DRC_C_DEF_STD: a.op = OP_DEF_STD;
			`DRC_C_DEF_US: a.op = OP_DEF_US;
			`DRC_C_MODE_STD: a.op = OP_MODE_STD;
			`DRC_C_MODE_US: a.op = OP_MODE_US;
			`DRC_C_MODE_STDK: a.op = OP_MODE_STD_KEEP;
			`DRC_C_MODE_USK: a.op = OP_MODE_US_KEEP;
			`DRC_C_BOOT_DIFF: begin
				a.op = OP_BOOT_DIFF;
				a.arg = 10'h001;
			end
			`DRC_C_WARN_CLR: a.op = OP_WARN_CLR;
			`DRC_C_WARN_SET: a.op = OP_WARN_SET;
			`DRC_C_RO_CLR: a.op = OP_RO_CLR;
			`DRC_C_RO_SET: a.op = OP_RO_SET;
			`DRC_C_ERASE: a.op = OP_CARD_ERASE;
			default: begin
				a.op = OP_NONE;
				a.req = 1'b0;
				if (c >= `DRC_C_BLK_LO && c <= `DRC_C_BLK_HI) begin
					// Strip thousands one at a time; leftover is the block
					a.op = OP_CARD_FULL;
					r = c - `DRC_C_BLK_LO;
					for (int i = 0; i < 5; i++) begin
						if (r >= `DRC_C_THOUSAND) begin
							r = r - `DRC_C_THOUSAND;
							a.op = drc_op_type'(a.op + 5'h01);
						end
					end
					a.arg = r[9:0];
					a.req = 1'b1;
				end
				if (c >= `DRC_C_NP_LO && c <= `DRC_C_NP_HI) begin
					r = c - `DRC_C_NP_LO;
					a.op = OP_NAMEPLATE;
					a.arg = r[9:0];
					a.req = 1'b1;
				end
			end
		endcase
		return a;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic wr;
		logic rd;
		logic setup;
		logic keypad;
		drc_keys_type kp;
		logic src_key;
		logic src_param;
		logic src_host;
		logic src_auto;
		logic any_src;
		logic accept;
		logic seq_ok;
		logic [2:0] run_now;
		logic [15:0] step;
		logic card_wr;
		drc_act_type dec;
		next_st = st;
		wr = psel && penable && st.pready && pwrite;
		rd = psel && !penable;
		setup = psel && !penable;
		keypad = st.reference_selector == `DRC_SEL_KEYPAD;
		kp = keys & ~st.keys_q;
		run_now = {seq.run_fwd, seq.run_rev, seq.run};
		dec = decode(st.command_param);
		step = 16'h0001;
		card_wr = 1'b0;
		next_st.keys_q = keys;
		next_st.run_q = run_now;
		next_st.drive_reset = 1'b0;
		next_st.restart = 1'b0;
		next_st.action_trip = 1'b0;
		next_st.key_run_cmd = 1'b0;
		next_st.key_stop_cmd = 1'b0;
		next_st.key_rev_cmd = 1'b0;
		next_st.host_hit = 1'b0;

		// No wait state: answer is prepared in the setup cycle
		next_st.pready = setup;
		next_st.pslverr = 1'b0;
		if (rd) begin
			next_st.prdata = 32'h0000_0000;
			case (paddr)
				`DRC_A_CTRL: begin
					next_st.prdata[`DRC_B_SEL +: 3] = st.reference_selector;
					next_st.prdata[`DRC_B_REV] = st.reverse_key_enable;
					next_st.prdata[`DRC_B_STOPFN] = st.stop_fn_en;
					next_st.prdata[`DRC_B_LATCH] = st.latch_seq;
					next_st.prdata[`DRC_B_MSET] = st.motor_set_selector;
					next_st.prdata[`DRC_B_AUTO +: 4] = st.auto_reset_setting;
					next_st.prdata[`DRC_B_COPY +: 3] = st.card_copy_mode;
				end
				`DRC_A_CMD: next_st.prdata[15:0] = st.command_param;
				`DRC_A_RSTREQ: next_st.prdata[0] = st.reset_request_param;
				`DRC_A_UTRIP: next_st.prdata[7:0] = st.user_trip_param;
				`DRC_A_STAT: next_st.prdata[15:0] = {st.auto_cnt,
					st.display_filter, st.pwr_busy, st.wait_edge, st.result,
					st.busy, hw_fault_trip, memory_fault_trip, trip_active,
					st.flash_cnt != 32'h0, st.show_keyref};
				`DRC_A_KREF: next_st.prdata[15:0] = st.keyref;
				default: next_st.pslverr = 1'b1;
			endcase
			if (!pwrite && paddr > `DRC_A_KREF)
				next_st.pslverr = 1'b1;
			if (pwrite && (paddr == `DRC_A_STAT || paddr == `DRC_A_KREF ||
					paddr[1:0] != 2'b00 || paddr > `DRC_A_KREF))
				next_st.pslverr = 1'b1;
		end

		////////////////////////////////////////////////////////////////////
		// Reset sources
		src_key = 1'b0;
		if (kp.stop) begin
			if (!st.stop_fn_en || !running)
				src_key = 1'b1;
			else if (keys.run)
				src_key = 1'b1;
			else if (keypad)
				next_st.key_stop_cmd = 1'b1;
		end
		if (keypad && kp.run)
			next_st.key_run_cmd = 1'b1;
		if (keypad && kp.rev && st.reverse_key_enable)
			next_st.key_rev_cmd = 1'b1;
		src_param = st.reset_request_param && !st.rst_req_q;
		next_st.rst_req_q = st.reset_request_param;
		src_host = st.host_hit;
		// Auto reset retries a trip after a delay, up to the set count
		src_auto = 1'b0;
		if (trip_active && st.auto_cnt < st.auto_reset_setting) begin
			if (st.auto_tmr + 32'h1 >= AUTO_CYC[31:0]) begin
				src_auto = 1'b1;
				next_st.auto_tmr = 32'h0;
				next_st.auto_cnt = st.auto_cnt + 4'h1;
			end else begin
				next_st.auto_tmr = st.auto_tmr + 32'h1;
			end
		end else begin
			next_st.auto_tmr = 32'h0;
		end
		if (!trip_active && !st.busy)
			next_st.auto_cnt = 4'h0;
		any_src = src_key || src_param || src_host || src_auto;
		accept = any_src && !hw_fault_trip;
		if (memory_fault_trip)
			accept = accept && (st.command_param == `DRC_C_DEF_STD ||
				st.command_param == `DRC_C_DEF_US);

		////////////////////////////////////////////////////////////////////
		// Restart gating
		seq_ok = seq.enable && (|run_now);
		if (st.latch_seq)
			seq_ok = seq_ok && seq.not_stop;
		if (accept) begin
			next_st.drive_reset = 1'b1;
			if (trip_active) begin
				if (src_key) begin
					next_st.wait_edge = 1'b1;
				end else begin
					next_st.wait_edge = 1'b0;
					next_st.restart = seq_ok;
				end
			end
		end else if (st.wait_edge && |(run_now & ~st.run_q)) begin
			next_st.wait_edge = 1'b0;
			next_st.restart = 1'b1;
		end

		////////////////////////////////////////////////////////////////////
		// Action dispatch on reset
		if (accept && !st.busy && dec.req) begin
			if (dec.op == OP_SAVE && (undervoltage_flag || aux_supply_flag))
				next_st.result = RES_REFUSED;
			else begin
				next_st.act = dec;
				next_st.busy = 1'b1;
				next_st.result = RES_NONE;
			end
		end
		if (st.busy) begin
			if (act_ack.done) begin
				next_st.busy = 1'b0;
				next_st.act.req = 1'b0;
				next_st.result = RES_DONE;
				next_st.command_param = 16'h0000;
				if (st.act.op == OP_BOOT_DIFF)
					next_st.card_copy_mode = 3'h0;
				card_wr = st.act.op == OP_BOOT_DIFF ||
					st.act.op == OP_CARD_FULL ||
					st.act.op == OP_CARD_DIFF ||
					st.act.op == OP_CARD_LADDER;
			end else if (act_ack.refused) begin
				next_st.busy = 1'b0;
				next_st.act.req = 1'b0;
				next_st.result = RES_REFUSED;
			end else if (act_ack.failed) begin
				next_st.busy = 1'b0;
				next_st.act.req = 1'b0;
				next_st.result = RES_FAILED;
				next_st.action_trip = 1'b1;
			end
		end
		// Display filters need no reset and act at once
		if (st.command_param == `DRC_C_DISP_ND)
			next_st.display_filter = 2'b01;
		else if (st.command_param == `DRC_C_DISP_DST)
			next_st.display_filter = 2'b10;
		else
			next_st.display_filter = 2'b00;

		////////////////////////////////////////////////////////////////////
		// Card write indication
		if (card_wr)
			next_st.flash_cnt = FLASH_CYC[31:0];
		else if (st.flash_cnt != 32'h0)
			next_st.flash_cnt = st.flash_cnt - 32'h1;

		////////////////////////////////////////////////////////////////////
		// Power-up option copy wait, bounded so a dead module cannot hang
		if (!st.pwr_started) begin
			next_st.pwr_started = 1'b1;
			next_st.pwr_busy = opt_copy_req;
			next_st.pwr_cnt = OPT_WAIT_CYC[31:0];
		end else if (st.pwr_busy) begin
			if (opt_copy_done || st.pwr_cnt <= 32'h1)
				next_st.pwr_busy = 1'b0;
			next_st.pwr_cnt = st.pwr_cnt - 32'h1;
		end

		////////////////////////////////////////////////////////////////////
		// Keypad reference
		if (st.hold_cnt >= `DRC_HOLD_FAST)
			step = 16'h0064;
		else if (st.hold_cnt >= `DRC_HOLD_MID)
			step = 16'h000a;
		if (keypad && status_mode && (keys.up ^ keys.down)) begin
			next_st.show_keyref = 1'b1;
			if ((kp.up || kp.down) ||
					st.step_tmr + 32'h1 >= STEP_CYC[31:0]) begin
				next_st.step_tmr = 32'h0;
				if (!(kp.up || kp.down) && st.hold_cnt != 8'hff)
					next_st.hold_cnt = st.hold_cnt + 8'h01;
				if (keys.up)
					next_st.keyref = (KEYREF_MAX - st.keyref < step) ?
						KEYREF_MAX : st.keyref + step;
				else
					next_st.keyref = (st.keyref < step) ?
						16'h0000 : st.keyref - step;
			end else begin
				next_st.step_tmr = st.step_tmr + 32'h1;
			end
		end else begin
			next_st.hold_cnt = 8'h00;
			next_st.step_tmr = 32'h0;
			if (!status_mode || !keypad)
				next_st.show_keyref = 1'b0;
		end

		////////////////////////////////////////////////////////////////////
		// Register writes; a software write beats a hardware clear
		if (wr) begin
			case (paddr)
				`DRC_A_CTRL: begin
					next_st.reference_selector = pwdata[`DRC_B_SEL +: 3];
					next_st.reverse_key_enable = pwdata[`DRC_B_REV];
					next_st.stop_fn_en = pwdata[`DRC_B_STOPFN];
					next_st.latch_seq = pwdata[`DRC_B_LATCH];
					next_st.motor_set_selector = pwdata[`DRC_B_MSET];
					next_st.auto_reset_setting = pwdata[`DRC_B_AUTO +: 4];
					next_st.card_copy_mode = pwdata[`DRC_B_COPY +: 3];
				end
				`DRC_A_CMD: next_st.command_param = pwdata[15:0];
				`DRC_A_RSTREQ: next_st.reset_request_param = pwdata[0];
				`DRC_A_UTRIP: begin
					next_st.user_trip_param = pwdata[7:0];
					next_st.host_hit = pwdata[7:0] == `DRC_UTRIP_RESET;
				end
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.reference_selector <= 3'(`DRC_RST_CTRL);
			st.command_param <= `DRC_RST_CMD;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign act = st.act;
	assign drive_reset = st.drive_reset;
	assign restart = st.restart;
	assign action_trip = st.action_trip;
	assign key_run_cmd = st.key_run_cmd;
	assign key_stop_cmd = st.key_stop_cmd;
	assign key_rev_cmd = st.key_rev_cmd;
	assign keypad_reference = st.keyref;
	assign show_keyref = st.show_keyref;
	assign alt_motor_set = st.motor_set_selector;
	assign dp_alt_set = st.motor_set_selector;
	// Blink rate taken from the countdown itself, no extra divider
	assign dp_right = st.flash_cnt[24];
	assign display_filter = st.display_filter;
	assign powerup_busy = st.pwr_busy;

endmodule

/* File: pkg/drc_defines.svh */
// Register map, field positions, codes and timing constants
`ifndef DRC_DEFINES_SVH
`define DRC_DEFINES_SVH
`define DRC_A_CTRL 8'h00
`define DRC_A_CMD 8'h04
`define DRC_A_RSTREQ 8'h08
`define DRC_A_UTRIP 8'h0c
`define DRC_A_STAT 8'h10
`define DRC_A_KREF 8'h14
`define DRC_B_SEL 0
`define DRC_B_REV 3
`define DRC_B_STOPFN 4
`define DRC_B_LATCH 5
`define DRC_B_MSET 6
`define DRC_B_AUTO 8
`define DRC_B_COPY 12
`define DRC_RST_CTRL 32'h0000_0000
`define DRC_RST_CMD 16'h0000
`define DRC_SEL_KEYPAD 3'h4
`define DRC_UTRIP_RESET 8'h64
`define DRC_C_SAVE 16'h03e8
`define DRC_C_SAVE_ANY 16'h03e9
`define DRC_C_OPT_RST 16'h042e
`define DRC_C_DEF_STD 16'h04d1
`define DRC_C_DEF_US 16'h04dc
`define DRC_C_MODE_STD 16'h04e5
`define DRC_C_MODE_US 16'h04e6
`define DRC_C_MODE_STDK 16'h04e7
`define DRC_C_MODE_USK 16'h04e8
`define DRC_C_BOOT_DIFF 16'h07d1
`define DRC_C_BLK_LO 16'h0bb8
`define DRC_C_BLK_HI 16'h2327
`define DRC_C_THOUSAND 16'h03e8
`define DRC_C_WARN_CLR 16'h2553
`define DRC_C_WARN_SET 16'h25c2
`define DRC_C_RO_CLR 16'h2631
`define DRC_C_RO_SET 16'h26a0
`define DRC_C_ERASE 16'h270f
`define DRC_C_NP_LO 16'h2af8
`define DRC_C_NP_HI 16'h2b5b
`define DRC_C_DISP_ND 16'h2ee0
`define DRC_C_DISP_DST 16'h2ee1
`define DRC_CLK_MHZ 100
`define DRC_FLASH_MS 2000
`define DRC_OPT_WAIT_MS 5000
`define DRC_STEP_MS 100
`define DRC_AUTO_MS 1000
`define DRC_FLASH_CYC (`DRC_FLASH_MS * 1000 * `DRC_CLK_MHZ)
`define DRC_OPT_WAIT_CYC (`DRC_OPT_WAIT_MS * 1000 * `DRC_CLK_MHZ)
`define DRC_STEP_CYC (`DRC_STEP_MS * 1000 * `DRC_CLK_MHZ)
`define DRC_AUTO_CYC (`DRC_AUTO_MS * 1000 * `DRC_CLK_MHZ)
`define DRC_HOLD_MID 8'h0a
`define DRC_HOLD_FAST 8'h14
`endif

/* File: pkg/drc_pkg.sv */
// Types shared by the reset and command decoder
package drc_pkg;
	typedef enum logic [4:0] {
		OP_NONE, OP_SAVE, OP_SAVE_ANY, OP_OPT_RESET, OP_DEF_STD, OP_DEF_US,
		OP_MODE_STD, OP_MODE_US, OP_MODE_STD_KEEP, OP_MODE_US_KEEP,
		OP_BOOT_DIFF, OP_CARD_FULL, OP_CARD_DIFF, OP_CARD_LADDER,
		OP_CARD_TO_DRIVE, OP_CARD_ERASE_BLK, OP_CARD_COMPARE,
		OP_WARN_CLR, OP_WARN_SET, OP_RO_CLR, OP_RO_SET, OP_CARD_ERASE,
		OP_NAMEPLATE
	} drc_op_type;
	typedef enum logic [1:0] {
		RES_NONE, RES_DONE, RES_REFUSED, RES_FAILED
	} drc_res_type;
	typedef struct packed {
		logic run;
		logic stop;
		logic rev;
		logic up;
		logic down;
	} drc_keys_type;
	typedef struct packed {
		logic enable;
		logic run_fwd;
		logic run_rev;
		logic run;
		logic not_stop;
	} drc_seq_type;
	typedef struct packed {
		logic req;
		drc_op_type op;
		logic [9:0] arg;
	} drc_act_type;
	typedef struct packed {
		logic done;
		logic refused;
		logic failed;
	} drc_ack_type;
endpackage

/* File: tb/drc_act_model.sv */
// Behavioural parameter store and card answering action requests
`timescale 1ns/1ns
module drc_act_model
	import drc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire drc_act_type act,
	input wire logic [1:0] mode,
	input wire logic [3:0] delay,
	output drc_ack_type act_ack
);
	logic [3:0] cnt;
	// Mode 0 done, 1 refused, 2 failed; delay gives a slow answer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 4'h0;
			act_ack <= '0;
		end else begin
			act_ack <= '0;
			cnt <= 4'h0;
			if (act.req && act_ack == '0 && cnt < delay) begin
				cnt <= cnt + 4'h1;
			end else if (act.req && act_ack == '0) begin
				act_ack <= '{done: mode == 2'h0, refused: mode == 2'h1,
					failed: mode == 2'h2};
			end
		end
	end
endmodule

/* File: tb/drc_core_assertions.sv */
// Port checker for the reset and command decoder
`timescale 1ns/1ns
module drc_core_assertions
	import drc_pkg::*;
#(
	parameter int OPT_WAIT_CYC = 100
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire drc_act_type act,
	input wire drc_ack_type act_ack,
	input wire drc_seq_type seq,
	input wire logic hw_fault_trip,
	input wire logic memory_fault_trip,
	input wire logic drive_reset,
	input wire logic restart,
	input wire logic action_trip,
	input wire logic alt_motor_set,
	input wire logic dp_alt_set,
	input wire logic powerup_busy
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	int busy_cnt;
	// Counter, since the wait is far beyond a repetition count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= powerup_busy ? busy_cnt + 1 : 0;
		end
	end
	////////////////////////////////////////
	pready_pulse_a: assert property (
		psel && !penable |=> pready ##1 !pready)
		else $error("ready not a single cycle after setup");
	err_with_ready_a: assert property (
		pslverr |-> pready && psel && penable)
		else $error("error response outside access");
	act_hold_a: assert property (
		act.req && act_ack == '0 |=> act.req && $stable(act.op))
		else $error("action request changed before answer");
	ack_release_a: assert property (
		act.req && act_ack.done |=> !act.req)
		else $error("action request held after done");
	fail_trip_a: assert property (
		act.req && act_ack.failed |=> action_trip)
		else $error("failed action raised no trip");
	trip_cause_a: assert property (
		action_trip |-> $past(act_ack.failed))
		else $error("trip without failed action");
	hw_block_a: assert property (
		hw_fault_trip && $past(hw_fault_trip) |-> !drive_reset)
		else $error("reset taken during hardware fault");
	mem_codes_a: assert property (
		memory_fault_trip && $past(memory_fault_trip) && drive_reset
		|-> act.req && act.op inside {OP_DEF_STD, OP_DEF_US})
		else $error("memory fault reset without defaults");
	restart_cause_a: assert property (
		restart && drive_reset |-> $past(seq.enable)
		&& $past(seq.run_fwd || seq.run_rev || seq.run))
		else $error("restart without enable and run");
	motor_dp_a: assert property (
		dp_alt_set == alt_motor_set)
		else $error("motor set indicator mismatch");
	pwr_wait_a: assert property (
		powerup_busy |-> busy_cnt <= OPT_WAIT_CYC + 2)
		else $error("power-up wait too long");
	cover property (restart);
	cover property (action_trip);
	cover property (act.req && act_ack.done);
endmodule
bind drc_core drc_core_assertions #(.OPT_WAIT_CYC(OPT_WAIT_CYC))
	i_drc_core_assertions (.pclk, .presetn, .psel, .penable, .pready,
	.pslverr, .act, .act_ack, .seq, .hw_fault_trip, .memory_fault_trip,
	.drive_reset, .restart, .action_trip, .alt_motor_set, .dp_alt_set,
	.powerup_busy);

/* File: tb/tb_drive_reset_and_command_decoder.sv */
// Self-checking bench for the reset and command decoder
`timescale 1ns/1ns
`include "drc_defines.svh"
module tb_drive_reset_and_command_decoder
	import drc_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, rerr;
	drc_keys_type keys = '0;
	drc_seq_type seq = '0;
	logic status_mode = 1'b0, running = 1'b0, trip_active = 1'b0;
	logic hw_fault_trip = 1'b0, memory_fault_trip = 1'b0;
	logic undervoltage_flag = 1'b0, aux_supply_flag = 1'b0;
	logic opt_copy_req = 1'b0, opt_copy_done = 1'b0;
	drc_ack_type act_ack;
	drc_act_type act;
	logic drive_reset, restart, action_trip, key_run_cmd, key_stop_cmd;
	logic key_rev_cmd, show_keyref, alt_motor_set, dp_alt_set, dp_right;
	logic powerup_busy, req_q = 1'b0;
	logic [15:0] keypad_reference;
	logic [1:0] display_filter, ack_mode = 2'h0;
	logic [3:0] ack_dly = 4'h0;
	drc_op_type last_op;
	logic [9:0] last_arg;
	int num_errors = 0, n_checks = 0, n_cyc = 0, k, m;
	int n_rst = 0, n_rs = 0, n_trip = 0, n_req = 0, n_krun = 0, n_krev = 0;
	logic [15:0] cmd_t [21] = '{`DRC_C_SAVE_ANY, `DRC_C_OPT_RST,
		`DRC_C_DEF_STD, `DRC_C_DEF_US, `DRC_C_MODE_STD, `DRC_C_MODE_US,
		`DRC_C_MODE_STDK, `DRC_C_MODE_USK, `DRC_C_BOOT_DIFF, 16'h0bbd,
		16'h0fac, 16'h176f, 16'h1777, 16'h1bbc, 16'h203a, `DRC_C_WARN_CLR,
		`DRC_C_WARN_SET, `DRC_C_RO_CLR, `DRC_C_RO_SET, `DRC_C_ERASE,
		16'h2b04};
	drc_op_type op_t [21] = '{OP_SAVE_ANY, OP_OPT_RESET, OP_DEF_STD,
		OP_DEF_US, OP_MODE_STD, OP_MODE_US, OP_MODE_STD_KEEP,
		OP_MODE_US_KEEP, OP_BOOT_DIFF, OP_CARD_FULL, OP_CARD_DIFF,
		OP_CARD_LADDER, OP_CARD_TO_DRIVE, OP_CARD_ERASE_BLK,
		OP_CARD_COMPARE, OP_WARN_CLR, OP_WARN_SET, OP_RO_CLR, OP_RO_SET,
		OP_CARD_ERASE, OP_NAMEPLATE};
	// Zero means the argument is not checked for that code
	logic [9:0] arg_t [21] = '{10'h0, 10'h0, 10'h0, 10'h0, 10'h0, 10'h0,
		10'h0, 10'h0, 10'h0, 10'h005, 10'h00c, 10'h3e7, 10'h007, 10'h064,
		10'h0fa, 10'h0, 10'h0, 10'h0, 10'h0, 10'h0, 10'h00c};

	drc_core #(.FLASH_CYC(200), .OPT_WAIT_CYC(100), .STEP_CYC(10),
		.AUTO_CYC(20)) i_drc_core (.*);
	drc_act_model i_drc_act_model (.pclk(pclk), .presetn(presetn),
		.act(act), .mode(ack_mode), .delay(ack_dly), .act_ack(act_ack));

	always #5 pclk = ~pclk;
	////////////////////////////////////////
	always @(posedge pclk) begin
		n_cyc++;
		n_rst += drive_reset === 1'b1;
		n_rs += restart === 1'b1;
		n_trip += action_trip === 1'b1;
		n_krun += key_run_cmd === 1'b1;
		n_krev += key_rev_cmd === 1'b1;
		req_q <= act.req;
		if (act.req === 1'b1 && req_q !== 1'b1) begin
			n_req++;
			last_op <= act.op;
			last_arg <= act.arg;
		end
		if (n_cyc == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cyc(input int c);
		repeat (c) @(posedge pclk);
	endtask

	// Holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic ureset();
		wr(`DRC_A_UTRIP, 32'h0000_0064);
		cyc(14);
	endtask
	////////////////////////////////////////
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(`DRC_A_CTRL);
		chk("ctrl_rst", `DRC_RST_CTRL, rdat);
		rd(8'h18);
		chk("unmapped_err", 32'h1, rerr);
		wr(`DRC_A_STAT, 32'h0);
		chk("stat_ro_err", 32'h1, rerr);
		wr(`DRC_A_CMD, 32'h0000_03e8);
		for (int j = 0; j < 3; j++) begin
			{undervoltage_flag, aux_supply_flag} <= 2'b10 >> j;
			k = n_req;
			m = n_rst;
			wr(`DRC_A_RSTREQ, 32'h0);
			wr(`DRC_A_RSTREQ, 32'h1);
			cyc(12);
			chk("rst_edge", m + 1, n_rst);
			chk("save_start", j == 2, n_req - k);
			rd(`DRC_A_CMD);
			chk("save_cmd", j == 2 ? 32'h0 : 32'h3e8, rdat);
		end
		chk("save_op", OP_SAVE, last_op);
		m = n_rst;
		wr(`DRC_A_RSTREQ, 32'h1);
		cyc(4);
		chk("rst_level", m, n_rst);
		$display("test save done");
		// Copy mode set first so its clearing is visible
		wr(`DRC_A_CTRL, 32'h0000_1000);
		for (int i = 0; i < 21; i++) begin
			ack_dly <= 4'(i % 4 * 3);
			wr(`DRC_A_CMD, {16'h0, cmd_t[i]});
			k = n_req;
			ureset();
			chk("act_start", k + 1, n_req);
			chk("act_op", op_t[i], last_op);
			if (arg_t[i] != 10'h0) chk("act_arg", arg_t[i], last_arg);
			rd(`DRC_A_CMD);
			chk("act_cmd_clr", 32'h0, rdat);
			if (i == 8) begin
				rd(`DRC_A_CTRL);
				chk("copy_clr", 32'h0, rdat[14:12]);
				rd(`DRC_A_STAT);
				chk("card_flash", 32'h1, rdat[1]);
			end
		end
		$display("test codes done");
		k = n_req;
		wr(`DRC_A_CMD, 32'h0000_05dc);
		ureset();
		rd(`DRC_A_CMD);
		chk("undef_cmd", 32'h5dc, rdat);
		wr(`DRC_A_CMD, {16'h0, `DRC_C_DISP_ND});
		cyc(2);
		chk("filter_nd", 32'h1, display_filter);
		wr(`DRC_A_CMD, {16'h0, `DRC_C_DISP_DST});
		cyc(2);
		chk("filter_dst", 32'h2, display_filter);
		chk("no_act", k, n_req);
		for (int j = 1; j < 3; j++) begin
			ack_mode <= j[1:0];
			m = n_trip;
			wr(`DRC_A_CMD, 32'h0000_03e9);
			ureset();
			chk("fail_trip", j == 2, n_trip - m);
			rd(`DRC_A_CMD);
			chk("fail_cmd", 32'h3e9, rdat);
		end
		ack_mode <= 2'h0;
		hw_fault_trip <= 1'b1;
		m = n_rst;
		ureset();
		chk("hw_block", m, n_rst);
		hw_fault_trip <= 1'b0;
		memory_fault_trip <= 1'b1;
		ureset();
		chk("mem_block", m, n_rst);
		wr(`DRC_A_CMD, {16'h0, `DRC_C_DEF_STD});
		ureset();
		chk("mem_accept", m + 1, n_rst);
		chk("mem_op", OP_DEF_STD, last_op);
		memory_fault_trip <= 1'b0;
		$display("test faults done");
		trip_active <= 1'b1;
		seq <= '{enable: 1'b1, run_fwd: 1'b1, default: 1'b0};
		for (int j = 0; j < 4; j++) begin
			wr(`DRC_A_CTRL, {26'h0, j[1], 5'h00});
			seq.not_stop <= j[0];
			m = n_rs;
			ureset();
			chk("restart", !j[1] || j[0], n_rs - m);
		end
		m = n_rst;
		wr(`DRC_A_CTRL, 32'h0000_0100);
		cyc(40);
		chk("auto_reset", m + 1, n_rst);
		k = n_rst;
		m = n_rs;
		keys <= '{stop: 1'b1, default: 1'b0};
		cyc(3);
		keys <= '0;
		seq.run_fwd <= 1'b0;
		cyc(3);
		chk("stop_rst", k + 1, n_rst);
		chk("stop_hold", m, n_rs);
		seq.run_fwd <= 1'b1;
		cyc(3);
		chk("stop_edge", m + 1, n_rs);
		trip_active <= 1'b0;
		seq <= '0;
		// Keypad select, reverse enable, then motor set alone
		for (int j = 0; j < 3; j++) begin
			wr(`DRC_A_CTRL, {25'h0, j == 2, 2'h0, j == 1, j < 2, 2'h0});
			m = n_krun;
			k = n_krev;
			keys <= '{run: 1'b1, rev: 1'b1, default: 1'b0};
			cyc(3);
			keys <= '0;
			cyc(3);
			chk("key_run", j < 2, n_krun - m);
			chk("key_rev", j == 1, n_krev - k);
		end
		chk("motor_set", 32'h1, alt_motor_set);
		wr(`DRC_A_CTRL, 32'h0000_0004);
		status_mode <= 1'b1;
		keys <= '{up: 1'b1, default: 1'b0};
		cyc(12);
		keys <= '0;
		cyc(2);
		chk("kref", 32'h2, keypad_reference);
		chk("kref_show", 32'h1, show_keyref);
		opt_copy_req <= 1'b1;
		presetn <= 1'b0;
		cyc(2);
		presetn <= 1'b1;
		cyc(2);
		chk("pwr_busy", 32'h1, powerup_busy);
		cyc(110);
		chk("pwr_done", 32'h0, powerup_busy);
		$display("test keys and power done");
		report_and_stop();
	end
endmodule
